/* operand_format_convert.sv */
`timescale 1ns/1ps
`default_nettype none
module operand_format_convert (
  input wire logic ref_clk,
  input wire logic rst,
  input wire opfmt_pkg::operand_req_t req,
  input wire logic req_valid,
  output opfmt_pkg::operand_out_t result_q,
  output logic result_valid_q
);
  import opfmt_pkg::*;

  short_float_t sf;
  single_float_t sp_in;
  ext_float_t x_in;
  ext_float_t sf_ext;
  ext_float_t sp_ext;
  single_float_t x_sp;
  logic sf_zero;
  logic sp_zero;
  logic x_zero;
  operand_out_t result_d;

  // field views of the raw inputs
  assign sf = short_float_t'(req.imm);
  assign sp_in = single_float_t'(req.reg_val[INT_W-1:0]);
  assign x_in = ext_float_t'(req.reg_val);

  // zero is decided by the exponent alone, as the format defines it
  assign sf_zero = (sf.exp == SHORT_ZERO_EXP);
  assign sp_zero = (sp_in.exp == WIDE_ZERO_EXP);
  assign x_zero = (x_in.exp == WIDE_ZERO_EXP);

  // short widened straight to extended; the single view is its top part
  always_comb
  begin
    sf_ext.exp = {{(EXP_W-SEXP_W){sf.exp[SEXP_W-1]}}, sf.exp};
    sf_ext.sign = sf.sign;
    sf_ext.frac = {sf.frac, {(XFRAC_W-SFRAC_W){1'b0}}};
    if (sf_zero)
    begin
      sf_ext.exp = WIDE_ZERO_EXP;
      sf_ext.sign = 1'b0;
      sf_ext.frac = '0;
    end
  end

  always_comb
  begin
    sp_ext.exp = sp_in.exp;
    sp_ext.sign = sp_in.sign;
    sp_ext.frac = {sp_in.frac, {PAD_X{1'b0}}};
    if (sp_zero)
    begin
      sp_ext.exp = WIDE_ZERO_EXP;
      sp_ext.sign = 1'b0;
      sp_ext.frac = '0;
    end
  end

  // truncation only; rounding belongs to the arithmetic units
  always_comb
  begin
    x_sp.exp = x_in.exp;
    x_sp.sign = x_in.sign;
    x_sp.frac = x_in.frac[XFRAC_W-1 -: SPFRAC_W];
  end

  always_comb
  begin
    result_d = '0;
    unique case (req.sel)
      SRC_IMM_SIGNED:
      begin
        result_d.int_op = {{(INT_W-SHORT_W){req.imm[SHORT_W-1]}}, req.imm};
        result_d.is_zero = (req.imm == '0);
      end
      SRC_IMM_UNSIGNED:
      begin
        result_d.int_op = {{(INT_W-SHORT_W){1'b0}}, req.imm};
        result_d.is_zero = (req.imm == '0);
      end
      SRC_REG_INT:
      begin
        // upper byte is neither read nor passed on
        result_d.int_op = req.reg_val[INT_W-1:0];
        result_d.is_zero = (req.reg_val[INT_W-1:0] == '0);
      end
      SRC_IMM_FLOAT:
      begin
        result_d.ext_op = sf_ext;
        result_d.mul_op = single_float_t'(sf_ext[EXT_W-1 -: INT_W]);
        result_d.is_zero = sf_zero;
      end
      SRC_REG_SINGLE:
      begin
        result_d.ext_op = sp_ext;
        result_d.mul_op = single_float_t'(sp_ext[EXT_W-1 -: INT_W]);
        result_d.is_zero = sp_zero;
      end
      SRC_REG_EXTENDED:
      begin
        result_d.ext_op = x_in;
        result_d.mul_op = x_sp;
        result_d.is_zero = x_zero;
      end
      default:
      begin
        result_d = '0;
      end
    endcase
  end

  // one register stage, the same for every format: conversion costs no cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      result_q <= '0;
    else
      result_q <= result_d;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      result_valid_q <= 1'b0;
    else
      result_valid_q <= req_valid;
  end

  a_signed_imm_ext: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid && req.sel == SRC_IMM_SIGNED
    |=> result_q.int_op[INT_W-1:SHORT_W] == {(INT_W-SHORT_W){$past(req.imm[SHORT_W-1])}})
    else $error("signed immediate not sign-extended");

  a_unsigned_imm_fill: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_UNSIGNED |=> result_q.int_op == {16'h0000, $past(req.imm)})
    else $error("unsigned immediate not zero-filled");

  a_reg_int_low: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_INT |=> result_q.int_op == $past(req.reg_val[INT_W-1:0]))
    else $error("register integer operand wrong");

  a_short_zero_wide: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_FLOAT && req.imm[SHORT_W-1 -: SEXP_W] == SHORT_ZERO_EXP
    |=> result_q.ext_op == {WIDE_ZERO_EXP, 32'h0000_0000} && result_q.is_zero)
    else $error("short zero not widened to zero");

  a_short_exp_ext: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_FLOAT && req.imm[SHORT_W-1 -: SEXP_W] != SHORT_ZERO_EXP
    |=> $signed(result_q.mul_op.exp) == $signed($past(req.imm[SHORT_W-1 -: SEXP_W]))
        && result_q.mul_op.frac[PAD_SP-1:0] == '0)
    else $error("short exponent not sign-extended");

  a_single_pad: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_SINGLE && req.reg_val[INT_W-1 -: EXP_W] != WIDE_ZERO_EXP
    |=> result_q.ext_op == {$past(req.reg_val[INT_W-1:0]), 8'h00})
    else $error("single not padded to extended");

  a_ext_truncate: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_EXTENDED |=> result_q.mul_op == $past(req.reg_val[EXT_W-1:PAD_X]))
    else $error("extended not truncated to single");

  a_valid_latency: assert property (@(posedge ref_clk) disable iff (rst)
    req_valid |=> result_valid_q ##1 (result_valid_q == $past(req_valid)))
    else $error("operand latency not one cycle");

  a_ext_zero_flag: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_EXTENDED |=> result_q.is_zero == ($past(req.reg_val[EXT_W-1 -: EXP_W]) == WIDE_ZERO_EXP))
    else $error("extended zero flag wrong");

  a_signed_low_half: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_SIGNED
    |=> result_q.int_op[SHORT_W-1:0] == $past(req.imm))
    else $error("signed immediate low half wrong");

  a_signed_zero_flag: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_SIGNED
    |=> result_q.is_zero == ($past(req.imm) == '0))
    else $error("signed immediate zero flag wrong");

  a_signed_value: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_SIGNED
    |=> $signed(result_q.int_op) == $signed($past(req.imm)))
    else $error("signed immediate value changed");

  a_unsigned_zero_flag: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_UNSIGNED
    |=> result_q.is_zero == ($past(req.imm) == '0))
    else $error("unsigned immediate zero flag wrong");

  a_unsigned_no_sign: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_UNSIGNED
    |=> result_q.int_op[INT_W-1:SHORT_W] == '0)
    else $error("unsigned immediate upper half not clear");

  a_signed_no_float: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_SIGNED
    |=> result_q.ext_op == '0 && result_q.mul_op == '0)
    else $error("signed immediate leaks into float operands");

  a_unsigned_no_float: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_UNSIGNED
    |=> result_q.ext_op == '0 && result_q.mul_op == '0)
    else $error("unsigned immediate leaks into float operands");

  a_reg_int_no_float: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_INT
    |=> result_q.ext_op == '0 && result_q.mul_op == '0)
    else $error("register integer leaks into float operands");

  a_reg_int_zero: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_INT
    |=> result_q.is_zero == ($past(req.reg_val[INT_W-1:0]) == '0))
    else $error("register integer zero flag wrong");

  a_float_no_int: assert property (@(posedge ref_clk) disable iff (rst)
    (req.sel == SRC_IMM_FLOAT || req.sel == SRC_REG_SINGLE || req.sel == SRC_REG_EXTENDED)
    |=> result_q.int_op == '0)
    else $error("float source leaks into integer operand");

  a_short_sign_frac: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_FLOAT && req.imm[SHORT_W-1 -: SEXP_W] != SHORT_ZERO_EXP
    |=> result_q.mul_op.sign == $past(req.imm[SFRAC_W])
        && result_q.mul_op.frac[SPFRAC_W-1 -: SFRAC_W] == $past(req.imm[SFRAC_W-1:0]))
    else $error("short float sign or fraction misplaced");

  a_short_ext_frac: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_FLOAT && req.imm[SHORT_W-1 -: SEXP_W] != SHORT_ZERO_EXP
    |=> result_q.ext_op.frac == {$past(req.imm[SFRAC_W-1:0]), {(XFRAC_W-SFRAC_W){1'b0}}})
    else $error("short float fraction not padded in extended");

  a_short_ext_exp: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_FLOAT && req.imm[SHORT_W-1 -: SEXP_W] != SHORT_ZERO_EXP
    |=> $signed(result_q.ext_op.exp) == $signed($past(req.imm[SHORT_W-1 -: SEXP_W])))
    else $error("short float exponent not sign-extended in extended");

  a_short_ext_sign: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_FLOAT && req.imm[SHORT_W-1 -: SEXP_W] != SHORT_ZERO_EXP
    |=> result_q.ext_op.sign == $past(req.imm[SFRAC_W]))
    else $error("short float sign lost in extended");

  a_short_zero_flag: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_FLOAT
    |=> result_q.is_zero == ($past(req.imm[SHORT_W-1 -: SEXP_W]) == SHORT_ZERO_EXP))
    else $error("short float zero flag wrong");

  a_short_nonzero: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_FLOAT && req.imm[SHORT_W-1 -: SEXP_W] != SHORT_ZERO_EXP
    |=> !result_q.is_zero)
    else $error("short float wrongly flagged zero");

  a_short_mul_match: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_IMM_FLOAT
    |=> result_q.mul_op == result_q.ext_op[EXT_W-1 -: INT_W])
    else $error("short float single view differs from extended");

  a_single_zero_wide: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_SINGLE && req.reg_val[INT_W-1 -: EXP_W] == WIDE_ZERO_EXP
    |=> result_q.ext_op == {WIDE_ZERO_EXP, 32'h0000_0000} && result_q.is_zero
        && result_q.mul_op == {WIDE_ZERO_EXP, 24'h00_0000})
    else $error("single zero not widened to zero");

  a_single_mul_pass: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_SINGLE && req.reg_val[INT_W-1 -: EXP_W] != WIDE_ZERO_EXP
    |=> result_q.mul_op == $past(req.reg_val[INT_W-1:0]))
    else $error("single operand not passed to multiplier");

  a_single_flag: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_SINGLE
    |=> result_q.is_zero == ($past(req.reg_val[INT_W-1 -: EXP_W]) == WIDE_ZERO_EXP))
    else $error("single zero flag wrong");

  a_single_sign_keep: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_SINGLE && req.reg_val[INT_W-1 -: EXP_W] != WIDE_ZERO_EXP
    |=> result_q.ext_op.sign == $past(req.reg_val[SPFRAC_W])
        && result_q.ext_op.exp == $past(req.reg_val[INT_W-1 -: EXP_W]))
    else $error("single sign or exponent lost in extended");

  a_single_ext_frac: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_SINGLE
    |=> result_q.ext_op.frac[PAD_X-1:0] == '0)
    else $error("single widening left low fraction bits set");

  a_ext_pass: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_EXTENDED
    |=> result_q.ext_op == $past(req.reg_val))
    else $error("extended operand not passed through");

  a_ext_exp_keep: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_EXTENDED
    |=> result_q.mul_op.exp == $past(req.reg_val[EXT_W-1 -: EXP_W])
        && result_q.mul_op.sign == $past(req.reg_val[XFRAC_W]))
    else $error("extended narrowing changed exponent or sign");

  a_ext_zero_keep: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_EXTENDED && req.reg_val[EXT_W-1 -: EXP_W] == WIDE_ZERO_EXP
    |=> result_q.ext_op.exp == WIDE_ZERO_EXP && result_q.is_zero)
    else $error("extended zero not kept");

  a_ext_nonzero: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel == SRC_REG_EXTENDED && req.reg_val[EXT_W-1 -: EXP_W] != WIDE_ZERO_EXP
    |=> !result_q.is_zero)
    else $error("extended operand wrongly flagged zero");

  a_illegal_sel_zero: assert property (@(posedge ref_clk) disable iff (rst)
    req.sel > SRC_REG_EXTENDED
    |=> result_q == '0)
    else $error("unknown source code gave non-zero operand");

  a_valid_drop: assert property (@(posedge ref_clk) disable iff (rst)
    !req_valid
    |=> !result_valid_q)
    else $error("result valid without a request");

  c_signed_neg: cover property (@(posedge ref_clk) disable iff (rst)
    req_valid && req.sel == SRC_IMM_SIGNED && req.imm[SHORT_W-1]);
  c_short_zero: cover property (@(posedge ref_clk) disable iff (rst)
    req_valid && req.sel == SRC_IMM_FLOAT && sf_zero);
  c_ext_narrow: cover property (@(posedge ref_clk) disable iff (rst)
    req_valid && req.sel == SRC_REG_EXTENDED ##1 req_valid && req.sel == SRC_REG_SINGLE);
  c_unsigned_top: cover property (@(posedge ref_clk) disable iff (rst)
    req_valid && req.sel == SRC_IMM_UNSIGNED && req.imm[SHORT_W-1]);
  c_single_zero: cover property (@(posedge ref_clk) disable iff (rst)
    req_valid && req.sel == SRC_REG_SINGLE && sp_zero);

endmodule // operand_format_convert
`default_nettype wire

/* opfmt_pkg.sv */
`default_nettype none
package opfmt_pkg;

  localparam int SHORT_W = 16;
  localparam int INT_W = 32;
  localparam int EXT_W = 40;
  localparam int SEXP_W = 4;
  localparam int SFRAC_W = 11;
  localparam int EXP_W = 8;
  localparam int SPFRAC_W = 23;
  localparam int XFRAC_W = 31;
  localparam int PAD_SP = SPFRAC_W - SFRAC_W;
  localparam int PAD_X = XFRAC_W - SPFRAC_W;

  localparam logic [SEXP_W-1:0] SHORT_ZERO_EXP = 4'h8;
  localparam logic [EXP_W-1:0] WIDE_ZERO_EXP = 8'h80;

  typedef enum logic [2:0] {
    SRC_IMM_SIGNED,
    SRC_IMM_UNSIGNED,
    SRC_REG_INT,
    SRC_IMM_FLOAT,
    SRC_REG_SINGLE,
    SRC_REG_EXTENDED
  } src_sel_t;

  typedef struct packed {
    logic [SEXP_W-1:0] exp;
    logic sign;
    logic [SFRAC_W-1:0] frac;
  } short_float_t;

  typedef struct packed {
    logic [EXP_W-1:0] exp;
    logic sign;
    logic [SPFRAC_W-1:0] frac;
  } single_float_t;

  typedef struct packed {
    logic [EXP_W-1:0] exp;
    logic sign;
    logic [XFRAC_W-1:0] frac;
  } ext_float_t;

  typedef struct packed {
    src_sel_t sel;
    logic [SHORT_W-1:0] imm;
    logic [EXT_W-1:0] reg_val;
  } operand_req_t;

  typedef struct packed {
    logic [INT_W-1:0] int_op;
    ext_float_t ext_op;
    single_float_t mul_op;
    logic is_zero;
  } operand_out_t;

endpackage
`default_nettype wire

/* operand_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// arithmetic-side consumer: takes an operand in every cycle that result_valid is high, never stalls
module operand_sink (
  input wire logic ref_clk,
  input wire logic rst,
  input wire opfmt_pkg::operand_out_t result,
  input wire logic result_valid,
  output logic [7:0] taken_cnt_q
);
  import opfmt_pkg::*;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      taken_cnt_q <= 8'h00;
    else if (result_valid)
      taken_cnt_q <= taken_cnt_q + 8'h01;
  end
endmodule // operand_sink
`default_nettype wire

/* tb_numeric_operand_format_convert.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module tb_numeric_operand_format_convert;
  import opfmt_pkg::*;
  typedef struct packed {
    src_sel_t sel;
    logic [15:0] imm;
    logic [39:0] rv;
    logic [31:0] i;
    logic [39:0] x;
    logic [31:0] m;
    logic z;
  } row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  operand_req_t req = '0;
  logic req_valid = 1'b0;
  operand_out_t result_q;
  logic result_valid_q;
  logic [7:0] taken_cnt_q;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  row_t rows [11];
  operand_format_convert dut_u (.ref_clk(ref_clk), .rst(rst), .req(req), .req_valid(req_valid),
    .result_q(result_q), .result_valid_q(result_valid_q));
  operand_sink sink_u (.ref_clk(ref_clk), .rst(rst), .result(result_q), .result_valid(result_valid_q),
    .taken_cnt_q(taken_cnt_q));
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 200)
    begin
      error_cnt++;
      finish_test();
    end
  end
  initial
  begin
    rows[0] = {SRC_IMM_SIGNED, 16'h8001, 40'h0, 32'hffff8001, 40'h0, 32'h0, 1'b0};
    rows[1] = {SRC_IMM_UNSIGNED, 16'h8001, 40'h0, 32'h00008001, 40'h0, 32'h0, 1'b0};
    rows[2] = {SRC_REG_INT, 16'h0, 40'hab80000001, 32'h80000001, 40'h0, 32'h0, 1'b0};
    rows[3] = {SRC_REG_INT, 16'h0, 40'hff00000000, 32'h0, 40'h0, 32'h0, 1'b1};
    rows[4] = {SRC_IMM_FLOAT, 16'h8000, 40'h0, 32'h0, 40'h8000000000, 32'h80000000, 1'b1};
    rows[5] = {SRC_IMM_FLOAT, 16'h7fff, 40'h0, 32'h0, 40'h07fff00000, 32'h07fff000, 1'b0};
    rows[6] = {SRC_IMM_FLOAT, 16'h9000, 40'h0, 32'h0, 40'hf900000000, 32'hf9000000, 1'b0};
    rows[7] = {SRC_REG_SINGLE, 16'h0, 40'h0012abcdef, 32'h0, 40'h12abcdef00, 32'h12abcdef, 1'b0};
    rows[8] = {SRC_REG_SINGLE, 16'h0, 40'h0080000000, 32'h0, 40'h8000000000, 32'h80000000, 1'b1};
    rows[9] = {SRC_REG_EXTENDED, 16'h0, 40'h7fffffffa5, 32'h0, 40'h7fffffffa5, 32'h7fffffff, 1'b0};
    rows[10] = {src_sel_t'(3'h6), 16'hffff, 40'hffffffffff, 32'h0, 40'h0, 32'h0, 1'b0};
    repeat (6) @(posedge ref_clk);
    `CHK("reset valid", 1'b0, result_valid_q)
    `CHK("reset result", '0, result_q)
    rst <= 1'b0;
    // back to back: row k is checked at the edge that launches row k+1
    for (int k = 0; k <= 11; k++)
    begin
      @(posedge ref_clk);
      if (k < 11)
      begin
        req <= '{sel: rows[k].sel, imm: rows[k].imm, reg_val: rows[k].rv};
        req_valid <= 1'b1;
      end
      else
        req_valid <= 1'b0;
      #1;
      if (k > 0)
      begin
        `CHK("int_op", rows[k-1].i, result_q.int_op)
        `CHK("ext_op", rows[k-1].x, result_q.ext_op)
        `CHK("mul_op", rows[k-1].m, result_q.mul_op)
        `CHK("is_zero", rows[k-1].z, result_q.is_zero)
        `CHK("valid", 1'b1, result_valid_q)
      end
    end
    @(posedge ref_clk);
    #1;
    `CHK("valid off", 1'b0, result_valid_q)
    `CHK("taken", 8'd11, taken_cnt_q)
    // mid-run reset clears outputs at once, overriding the edge's load
    @(posedge ref_clk);
    req <= '{sel: SRC_IMM_SIGNED, imm: 16'hffff, reg_val: 40'h0};
    req_valid <= 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK("pre rst", 32'hffffffff, result_q.int_op)
    @(posedge ref_clk);
    rst <= 1'b1;
    #1;
    `CHK("async rst", '0, result_q)
    `CHK("async rst valid", 1'b0, result_valid_q)
    finish_test();
  end
endmodule // tb_numeric_operand_format_convert
`default_nettype wire
